// >>> src/time_stamp_pkg.sv
package time_stamp_pkg;
   // Clock and time figures
   localparam int CLK_FREQ_HZ = 125_000_000;
   localparam int MS_PER_SEC = 1000;
   localparam int SAMPLE_PERIOD_MS = 125;
   localparam int SETTLE_DELAY_MS = 5;
   localparam int MIN_PULSE_MS = 1;
   localparam logic [6:0] SAMPLE_MS_COUNT = 7'(SAMPLE_PERIOD_MS);
   localparam logic [2:0] SETTLE_MS_COUNT = 3'(SETTLE_DELAY_MS);
   localparam logic [2:0] MIN_PULSE_MS_COUNT = 3'(MIN_PULSE_MS);
   // Pull resistor codes
   localparam logic [2:0] PULL_NONE = 3'h0;
   localparam logic [2:0] PULL_UP_500K = 3'h1;
   localparam logic [2:0] PULL_UP_1M = 3'h2;
   localparam logic [2:0] PULL_UP_10M = 3'h3;
   localparam logic [2:0] PULL_DOWN_500K = 3'h4;
   localparam logic [2:0] PULL_RESET = PULL_UP_1M;
   localparam logic [1:0] STRENGTH_500K = 2'h0;
   localparam logic [1:0] STRENGTH_1M = 2'h1;
   localparam logic [1:0] STRENGTH_10M = 2'h2;
   // Edge select codes
   localparam logic [1:0] EDGE_FALLING = 2'h0;
   localparam logic [1:0] EDGE_RISING = 2'h1;
   localparam logic [1:0] EDGE_RESET = EDGE_FALLING;
   // Filter and tally
   localparam logic [5:0] FILTER_DIRECT = 6'h00;
   localparam logic [5:0] TALLY_RESET = 6'h00;
   localparam logic [5:0] MATCH_MAX = 6'h3f;
   // Buffer layout
   localparam int BUF_BYTES = 32;
   localparam int REC_BYTES = 10;
   localparam logic [4:0] REC0_BASE = 5'h00;
   localparam logic [4:0] REC1_BASE = 5'h10;
   localparam int REC_SUBSEC_LO = 0;
   localparam int REC_SUBSEC_HI = 1;
   localparam int REC_TIME = 2;
   localparam int REC_STATUS = 8;
   localparam int REC_SOURCE = 9;
   // Status byte bits
   localparam int ST_OSC = 0;
   localparam int ST_VDET2 = 2;
   localparam int ST_RSTOUT = 3;
   localparam int ST_LVL1 = 5;
   localparam int ST_LVL2 = 6;
   // Source byte bits
   localparam int SRC_EXT1 = 0;
   localparam int SRC_RSTOUT = 2;
   localparam int SRC_VDET2 = 3;
   localparam int SRC_OSC = 4;
   localparam int SRC_CMD = 5;
   typedef enum logic [1:0] {FILL_EMPTY = 2'b00, FILL_ONE = 2'b01, FILL_FULL = 2'b10} fill_t;
   typedef enum logic {CH_IDLE = 1'b0, CH_SETTLE = 1'b1} ch_state_t;
endpackage

// >>> src/event_channel.sv
`timescale 1ns/100ps
`default_nettype none
module event_channel (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic ms_tick,
   input wire logic sample_tick,
   input wire logic event_input_pin,
   input wire logic [5:0] filter_match_count,
   input wire logic [1:0] trigger_edge_select,
   output logic level_monitor,
   output logic event_pulse,
   output logic [5:0] external_event_tally
);
   import time_stamp_pkg::*;

   ch_state_t state_r, state_nxt;
   logic accepted_r, pending_r, cand_r;
   logic [5:0] match_r, match_nxt;
   logic [2:0] settle_r;
   logic qualify, settle_done;

   function automatic logic edge_hit(input logic [1:0] sel, input logic lvl);
      edge_hit = (sel == EDGE_FALLING) ? !lvl : (sel == EDGE_RISING) ? lvl : 1'b1;
   endfunction

   // Consecutive matching samples
   always_comb begin
      if (event_input_pin != cand_r) begin
         match_nxt = 6'h01;
      end else if (match_r == MATCH_MAX) begin
         match_nxt = match_r;
      end else begin
         match_nxt = match_r + 6'h01;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         cand_r <= event_input_pin;
         match_r <= 6'h00;
      end else if (sample_tick) begin
         cand_r <= event_input_pin;
         match_r <= match_nxt;
      end
   end

   // Direct mode takes any change held across a millisecond tick
   always_comb begin
      if (filter_match_count == FILTER_DIRECT) begin
         qualify = ms_tick && (event_input_pin != accepted_r);
      end else begin
         qualify = sample_tick && (event_input_pin != accepted_r) && (match_nxt >= filter_match_count);
      end
   end

   assign settle_done = (state_r == CH_SETTLE) && ms_tick && (settle_r == SETTLE_MS_COUNT - 3'h1);

   always_comb begin
      case (state_r)
         CH_IDLE: state_nxt = qualify ? CH_SETTLE : CH_IDLE;
         CH_SETTLE: state_nxt = settle_done ? CH_IDLE : CH_SETTLE;
         default: state_nxt = CH_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state_r <= CH_IDLE;
         settle_r <= 3'h0;
         pending_r <= event_input_pin;
         accepted_r <= event_input_pin;
      end else begin
         state_r <= state_nxt;
         if (state_r == CH_IDLE) begin
            settle_r <= 3'h0;
            pending_r <= event_input_pin;
         end else if (ms_tick) begin
            settle_r <= settle_r + 3'h1;
         end
         if (settle_done) begin
            accepted_r <= pending_r;
         end
      end
   end

   // Event, tally and monitor
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         event_pulse <= 1'b0;
         external_event_tally <= TALLY_RESET;
         level_monitor <= 1'b0;
      end else begin
         level_monitor <= event_input_pin;
         event_pulse <= settle_done && edge_hit(trigger_edge_select, pending_r);
         if (event_pulse) begin
            external_event_tally <= external_event_tally + 6'h01;
         end
      end
   end

   property p_tally_step;
      @(posedge ref_clk) disable iff (reset)
      event_pulse |=> external_event_tally == $past(external_event_tally) + 6'h01;
   endproperty
   a_tally_step: assert property (p_tally_step) else $error("tally did not step on event");

   property p_edge_rising;
      @(posedge ref_clk) disable iff (reset)
      (event_pulse && $past(trigger_edge_select) == EDGE_RISING) |-> accepted_r;
   endproperty
   a_edge_rising: assert property (p_edge_rising) else $error("rising event on low level");

   property p_monitor;
      @(posedge ref_clk) disable iff (reset)
      ##1 level_monitor == $past(event_input_pin);
   endproperty
   a_monitor: assert property (p_monitor) else $error("monitor does not follow pin");
endmodule
`default_nettype wire

// >>> src/time_stamp_event_trigger.sv
// Operation
// - Two independent external event channels, each a time stamp trigger source.
// - Three-bit pull select drives pad pull controls; reset value is 1M pull-up.
// - Filter samples every 125 ms and needs N consecutive matching samples.
// - Filter setting zero still accepts any pulse of at least 1 ms.
// - Input level is taken at a detected change; the event follows 5 ms later.
// - Setting N from 2 to 40 always detects pulses of N times 125 ms.
// - Two-bit edge select picks falling, rising or both edges.
// - Each channel keeps a readable 6-bit tally of detected events, 0 to 63.
// - Tallies count only external events, never internal or command triggers.
// - Level monitor bit per channel follows the pin level.
// - Every trigger captures current time stamp data into the buffer.
// - Write to the trigger address issues a command trigger capture.
// - Detection and capture keep running in the low-voltage safe state.
// - An interrupt request is raised on external or internal events.
// - A 32-byte memory holds the time stamp buffer.
// - Direct mode stores two records; memory mode is free software access.
// - When full, overwrite replaces record two; inhibit discards new captures.
// - Record holds subseconds, BCD or binary time, levels, statuses, source.
`timescale 1ns/100ps
`default_nettype none
module time_stamp_event_trigger #(
   parameter int MS_TICK_CYCLES = time_stamp_pkg::CLK_FREQ_HZ / time_stamp_pkg::MS_PER_SEC
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic event_input_pin_one,
   input wire logic event_input_pin_two,
   input wire logic [2:0] pull_select_one,
   input wire logic [2:0] pull_select_two,
   input wire logic [1:0] edge_select_one,
   input wire logic [1:0] edge_select_two,
   input wire logic [5:0] channel_one_filter,
   input wire logic [5:0] channel_two_filter,
   input wire logic reset_out_event,
   input wire logic vdet2_event,
   input wire logic osc_resume_event,
   input wire logic reset_out_status,
   input wire logic vdet2_status,
   input wire logic osc_stop_status,
   input wire logic cmd_trigger_enable,
   input wire logic cmd_trigger_write,
   input wire logic [9:0] rtc_subsec,
   input wire logic [47:0] rtc_bcd_time,
   input wire logic [47:0] rtc_bin_count,
   input wire logic bin_select,
   input wire logic sram_mode,
   input wire logic overwrite_enable,
   input wire logic buffer_clear,
   input wire logic ext_irq_enable,
   input wire logic int_irq_enable,
   input wire logic irq_clear,
   input wire logic [4:0] sw_addr,
   input wire logic sw_write,
   input wire logic [7:0] sw_wdata,
   output logic [7:0] sw_rdata,
   output logic pad_pull_up_one,
   output logic pad_pull_down_one,
   output logic [1:0] pad_pull_strength_one,
   output logic pad_pull_up_two,
   output logic pad_pull_down_two,
   output logic [1:0] pad_pull_strength_two,
   output logic level_monitor_one,
   output logic level_monitor_two,
   output logic [5:0] channel_one_tally,
   output logic [5:0] channel_two_tally,
   output logic [1:0] record_fill,
   output logic capture_done,
   output logic event_irq
);
   import time_stamp_pkg::*;

   logic [16:0] ms_cnt_r;
   logic [6:0] sample_cnt_r;
   logic ms_tick, sample_tick;
   logic [1:0] pin_v, lvl_v, ev_v;
   logic [2:0] pull_sel_v [2];
   logic [1:0] edge_sel_v [2];
   logic [5:0] filt_v [2];
   logic [5:0] tally_v [2];
   logic [3:0] pad_v [2];
   logic [7:0] buf_mem [BUF_BYTES];
   logic [7:0] rec_byte [REC_BYTES];
   logic [47:0] time_sel;
   logic int_trig, cmd_trig, any_trig, do_write;
   logic [4:0] wr_base;
   fill_t fill_r, fill_base, fill_nxt;

   // Decodes pull code into {up, down, strength}
   function automatic logic [3:0] pull_decode(input logic [2:0] code);
      case (code)
         PULL_UP_500K: pull_decode = {2'b10, STRENGTH_500K};
         PULL_UP_1M: pull_decode = {2'b10, STRENGTH_1M};
         PULL_UP_10M: pull_decode = {2'b10, STRENGTH_10M};
         PULL_DOWN_500K: pull_decode = {2'b01, STRENGTH_500K};
         default: pull_decode = {2'b00, STRENGTH_500K};
      endcase
   endfunction

   // Millisecond and sample ticks from the divider chain
   assign ms_tick = (ms_cnt_r == 17'(MS_TICK_CYCLES - 1));
   assign sample_tick = ms_tick && (sample_cnt_r == SAMPLE_MS_COUNT - 7'h01);

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ms_cnt_r <= 17'h0_0000;
         sample_cnt_r <= 7'h00;
      end else begin
         ms_cnt_r <= ms_tick ? 17'h0_0000 : ms_cnt_r + 17'h0_0001;
         if (sample_tick) begin
            sample_cnt_r <= 7'h00;
         end else if (ms_tick) begin
            sample_cnt_r <= sample_cnt_r + 7'h01;
         end
      end
   end

   assign pin_v = {event_input_pin_two, event_input_pin_one};
   assign pull_sel_v[0] = pull_select_one;
   assign pull_sel_v[1] = pull_select_two;
   assign edge_sel_v[0] = edge_select_one;
   assign edge_sel_v[1] = edge_select_two;
   assign filt_v[0] = channel_one_filter;
   assign filt_v[1] = channel_two_filter;

   // Two identical channels
   generate
      for (genvar ch = 0; ch < 2; ch++) begin : g_chan
         event_channel u_chan (
            .ref_clk(ref_clk),
            .reset(reset),
            .ms_tick(ms_tick),
            .sample_tick(sample_tick),
            .event_input_pin(pin_v[ch]),
            .filter_match_count(filt_v[ch]),
            .trigger_edge_select(edge_sel_v[ch]),
            .level_monitor(lvl_v[ch]),
            .event_pulse(ev_v[ch]),
            .external_event_tally(tally_v[ch])
         );

         always_ff @(posedge ref_clk) begin
            if (reset) begin
               pad_v[ch] <= pull_decode(PULL_RESET);
            end else begin
               pad_v[ch] <= pull_decode(pull_sel_v[ch]);
            end
         end
      end
   endgenerate

   assign {pad_pull_up_one, pad_pull_down_one, pad_pull_strength_one} = pad_v[0];
   assign {pad_pull_up_two, pad_pull_down_two, pad_pull_strength_two} = pad_v[1];
   assign level_monitor_one = lvl_v[0];
   assign level_monitor_two = lvl_v[1];
   assign channel_one_tally = tally_v[0];
   assign channel_two_tally = tally_v[1];

   // Trigger sources; no safe-state gating anywhere
   assign int_trig = reset_out_event || vdet2_event || osc_resume_event;
   assign cmd_trig = cmd_trigger_write && cmd_trigger_enable;
   assign any_trig = (|ev_v) || int_trig || cmd_trig;

   // Record assembly
   assign time_sel = bin_select ? rtc_bin_count : rtc_bcd_time;

   always_comb begin
      rec_byte[REC_SUBSEC_LO] = {rtc_subsec[1:0], 6'h00};
      rec_byte[REC_SUBSEC_HI] = rtc_subsec[9:2];
      for (int i = 0; i < 6; i++) begin
         rec_byte[REC_TIME + i] = time_sel[8*i +: 8];
      end
      rec_byte[REC_STATUS] = 8'h00;
      rec_byte[REC_STATUS][ST_OSC] = osc_stop_status;
      rec_byte[REC_STATUS][ST_VDET2] = vdet2_status;
      rec_byte[REC_STATUS][ST_RSTOUT] = reset_out_status;
      rec_byte[REC_STATUS][ST_LVL1] = lvl_v[0];
      rec_byte[REC_STATUS][ST_LVL2] = lvl_v[1];
      rec_byte[REC_SOURCE] = 8'h00;
      rec_byte[REC_SOURCE][SRC_EXT1 +: 2] = ev_v;
      rec_byte[REC_SOURCE][SRC_RSTOUT] = reset_out_event;
      rec_byte[REC_SOURCE][SRC_VDET2] = vdet2_event;
      rec_byte[REC_SOURCE][SRC_OSC] = osc_resume_event;
      rec_byte[REC_SOURCE][SRC_CMD] = cmd_trig;
   end

   // Fill bookkeeping; a capture in the clear cycle lands in record one
   always_comb begin
      fill_base = buffer_clear ? FILL_EMPTY : fill_r;
      do_write = 1'b0;
      wr_base = REC0_BASE;
      fill_nxt = fill_base;
      if (any_trig && !sram_mode) begin
         case (fill_base)
            FILL_EMPTY: begin
               do_write = 1'b1;
               fill_nxt = FILL_ONE;
            end
            FILL_ONE: begin
               do_write = 1'b1;
               wr_base = REC1_BASE;
               fill_nxt = FILL_FULL;
            end
            default: begin
               do_write = overwrite_enable;
               wr_base = REC1_BASE;
               fill_nxt = FILL_FULL;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         fill_r <= FILL_EMPTY;
         capture_done <= 1'b0;
      end else begin
         fill_r <= fill_nxt;
         capture_done <= do_write;
      end
   end

   assign record_fill = fill_r;

   // Buffer memory
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         for (int i = 0; i < BUF_BYTES; i++) begin
            buf_mem[i] <= 8'h00;
         end
      end else if (do_write) begin
         for (int i = 0; i < REC_BYTES; i++) begin
            buf_mem[wr_base + 5'(i)] <= rec_byte[i];
         end
      end else if (sram_mode && sw_write) begin
         buf_mem[sw_addr] <= sw_wdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         sw_rdata <= 8'h00;
      end else begin
         sw_rdata <= buf_mem[sw_addr];
      end
   end

   // Event interrupt request, set wins over clear
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         event_irq <= 1'b0;
      end else if (((|ev_v) && ext_irq_enable) || (int_trig && int_irq_enable)) begin
         event_irq <= 1'b1;
      end else if (irq_clear) begin
         event_irq <= 1'b0;
      end
   end

   property p_cmd_capture;
      @(posedge ref_clk) disable iff (reset)
      (cmd_trig && !sram_mode && fill_r == FILL_EMPTY && !buffer_clear) |=> capture_done && fill_r == FILL_ONE;
   endproperty
   a_cmd_capture: assert property (p_cmd_capture) else $error("command trigger not captured");

   property p_cmd_disabled;
      @(posedge ref_clk) disable iff (reset)
      (cmd_trigger_write && !cmd_trigger_enable && !(|ev_v) && !int_trig) |=> !capture_done;
   endproperty
   a_cmd_disabled: assert property (p_cmd_disabled) else $error("capture without enabled trigger");

   property p_inhibit;
      @(posedge ref_clk) disable iff (reset)
      (fill_r == FILL_FULL && !overwrite_enable && !buffer_clear) |=> !capture_done && fill_r == FILL_FULL;
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("full buffer overwritten in inhibit");

   property p_sram_no_capture;
      @(posedge ref_clk) disable iff (reset)
      sram_mode |=> !capture_done;
   endproperty
   a_sram_no_capture: assert property (p_sram_no_capture) else $error("capture in memory mode");

   property p_pull_default;
      @(posedge ref_clk) disable iff (reset)
      (pull_select_one == PULL_UP_1M) |=> pad_pull_up_one && !pad_pull_down_one
         && pad_pull_strength_one == STRENGTH_1M;
   endproperty
   a_pull_default: assert property (p_pull_default) else $error("pull decode wrong");

   property p_tally_internal;
      @(posedge ref_clk) disable iff (reset)
      (!ev_v[0] && int_trig) |=> channel_one_tally == $past(channel_one_tally);
   endproperty
   a_tally_internal: assert property (p_tally_internal) else $error("tally moved on internal trigger");

   property p_irq_set;
      @(posedge ref_clk) disable iff (reset)
      (int_trig && int_irq_enable) |=> event_irq ##1 (event_irq || $past(irq_clear));
   endproperty
   a_irq_set: assert property (p_irq_set) else $error("interrupt not raised");

   property p_sample_spacing;
      @(posedge ref_clk) disable iff (reset)
      sample_tick |=> !sample_tick [*8];
   endproperty
   a_sample_spacing: assert property (p_sample_spacing) else $error("sample ticks too close");
endmodule
`default_nettype wire

// >>> bench/event_source.sv
`timescale 1ns/100ps
`default_nettype none
module event_source (
   input wire logic ref_clk,
   input wire logic drive_en,
   input wire logic drive_level,
   input wire logic pull_up,
   input wire logic pull_down,
   output logic pin
);
   logic scramble_r = 1'b0;
   always @(posedge ref_clk) begin
      scramble_r <= ~scramble_r;
   end
   // Released pin follows the pad pull, else floats
   always_comb begin
      if (drive_en) begin
         pin = drive_level;
      end else if (pull_up) begin
         pin = 1'b1;
      end else if (pull_down) begin
         pin = 1'b0;
      end else begin
         pin = scramble_r;
      end
   end
endmodule
`default_nettype wire

// >>> bench/time_stamp_event_trigger_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module time_stamp_event_trigger_tb_top;
   import time_stamp_pkg::*;
   localparam int MS = 8;
   localparam int SP = MS * 125;
   logic ref_clk = 1'b0, reset = 1'b1;
   logic [1:0] drv_en = 2'b11, drv_lvl = 2'b00;
   logic pin_one, pin_two;
   logic [2:0] pull_select_one = PULL_RESET, pull_select_two = PULL_RESET;
   logic [1:0] edge_select_one = EDGE_RESET, edge_select_two = EDGE_RESET;
   logic [5:0] channel_one_filter = 6'h28, channel_two_filter = 6'h28;
   logic reset_out_event = 1'b0, vdet2_event = 1'b0, osc_resume_event = 1'b0;
   logic reset_out_status = 1'b0, vdet2_status = 1'b0, osc_stop_status = 1'b0;
   logic cmd_trigger_enable = 1'b0, cmd_trigger_write = 1'b0, bin_select = 1'b0;
   logic [9:0] rtc_subsec = 10'h000;
   logic [47:0] rtc_bcd_time = 48'h0000_0000_0000, rtc_bin_count = 48'h0000_0000_0000;
   logic sram_mode = 1'b0, overwrite_enable = 1'b1, buffer_clear = 1'b0;
   logic ext_irq_enable = 1'b0, int_irq_enable = 1'b0, irq_clear = 1'b0;
   logic [4:0] sw_addr = 5'h00;
   logic sw_write = 1'b0;
   logic [7:0] sw_wdata = 8'h00, sw_rdata;
   logic pad_pull_up_one, pad_pull_down_one, pad_pull_up_two, pad_pull_down_two;
   logic [1:0] pad_pull_strength_one, pad_pull_strength_two, record_fill;
   logic level_monitor_one, level_monitor_two, capture_done, event_irq;
   logic [5:0] channel_one_tally, channel_two_tally;
   int errors = 0, comparisons = 0, cyc = 0, caps = 0, n, t1, c0, lat;
   logic [5:0] t2;
   logic [3:0] pe;
   logic [7:0] rd;

   time_stamp_event_trigger #(.MS_TICK_CYCLES(MS)) DUT (
      .ref_clk, .reset, .event_input_pin_one(pin_one), .event_input_pin_two(pin_two),
      .pull_select_one, .pull_select_two, .edge_select_one, .edge_select_two,
      .channel_one_filter, .channel_two_filter, .reset_out_event, .vdet2_event,
      .osc_resume_event, .reset_out_status, .vdet2_status, .osc_stop_status,
      .cmd_trigger_enable, .cmd_trigger_write, .rtc_subsec, .rtc_bcd_time, .rtc_bin_count,
      .bin_select, .sram_mode, .overwrite_enable, .buffer_clear, .ext_irq_enable,
      .int_irq_enable, .irq_clear, .sw_addr, .sw_write, .sw_wdata, .sw_rdata,
      .pad_pull_up_one, .pad_pull_down_one, .pad_pull_strength_one, .pad_pull_up_two,
      .pad_pull_down_two, .pad_pull_strength_two, .level_monitor_one, .level_monitor_two,
      .channel_one_tally, .channel_two_tally, .record_fill, .capture_done, .event_irq);
   event_source src_one (.ref_clk, .drive_en(drv_en[0]), .drive_level(drv_lvl[0]),
      .pull_up(pad_pull_up_one), .pull_down(pad_pull_down_one), .pin(pin_one));
   event_source src_two (.ref_clk, .drive_en(drv_en[1]), .drive_level(drv_lvl[1]),
      .pull_up(pad_pull_up_two), .pull_down(pad_pull_down_two), .pin(pin_two));

   always #4 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (capture_done === 1'b1) begin
         caps <= caps + 1;
      end
   end

   task automatic tick(input int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic finish_test();
      $display("comparisons %0d, errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic pulse(input int ch, input int width, input int gap);
      drv_lvl[ch] = 1'b1;
      tick(width);
      drv_lvl[ch] = 1'b0;
      tick(gap);
   endtask
   task automatic rd_byte(input logic [4:0] a);
      sw_addr = a;
      tick(2);
      rd = sw_rdata;
   endtask
   function automatic int exp_events(input logic [1:0] sel, input int rises, input int falls);
      return (sel == EDGE_FALLING) ? falls : (sel == EDGE_RISING) ? rises : rises + falls;
   endfunction
   function automatic logic [3:0] pull_exp(input logic [2:0] c);
      case (c)
         PULL_UP_500K: return {2'b10, STRENGTH_500K};
         PULL_UP_1M: return {2'b10, STRENGTH_1M};
         PULL_UP_10M: return {2'b10, STRENGTH_10M};
         PULL_DOWN_500K: return {2'b01, STRENGTH_500K};
         default: return 4'b0000;
      endcase
   endfunction

   initial begin
      #800_000;
      errors++;
      $display("unexpected watchdog: expected 0, seen 1");
      finish_test();
   end

   initial begin
      void'($urandom(19468));
      tick(12);
      reset = 1'b0;
      tick(1);
      chk("pull one", pull_exp(PULL_RESET), {pad_pull_up_one, pad_pull_down_one, pad_pull_strength_one});
      chk("tallies", 16'h0000, {channel_one_tally, channel_two_tally, record_fill});
      $display("test reset done");
      drv_en = 2'b00;
      for (int c = 0; c < 8; c++) begin
         pull_select_one = 3'(c);
         pull_select_two = ~3'(c);
         tick(3);
         pe = pull_exp(3'(c));
         chk("pull one", pe, {pad_pull_up_one, pad_pull_down_one, pe[3:2] != 2'b00 ? pad_pull_strength_one : 2'b00});
         pe = pull_exp(~3'(c));
         chk("pull two", pe, {pad_pull_up_two, pad_pull_down_two, pe[3:2] != 2'b00 ? pad_pull_strength_two : 2'b00});
         if (pe[3:2] != 2'b00) begin
            chk("monitor two pulled", pe[3], level_monitor_two);
         end
      end
      pull_select_one = PULL_RESET;
      pull_select_two = PULL_RESET;
      drv_en = 2'b11;
      for (int i = 0; i < 6; i++) begin
         drv_lvl = 2'($urandom);
         tick(3);
         chk("monitors", drv_lvl, {level_monitor_two, level_monitor_one});
      end
      drv_lvl = 2'b00;
      tick(2 * SP);
      chk("tallies quiet", 16'h0000, {channel_one_tally, channel_two_tally});
      $display("test pull and monitor done");
      channel_one_filter = FILTER_DIRECT;
      ext_irq_enable = 1'b1;
      t1 = 0;
      for (int sel = 0; sel < 4; sel++) begin
         edge_select_one = 2'(sel);
         c0 = caps;
         if (sel == 1) begin
            drv_lvl[0] = 1'b1;
            n = cyc;
            for (int w = 0; w < 100 && capture_done !== 1'b1; w++) begin
               tick(1);
            end
            lat = cyc - n;
            chk("latency in window", 1, lat >= 5 * MS && lat <= 6 * MS + 4);
            tick(80);
            drv_lvl[0] = 1'b0;
            tick(80);
            pulse(0, 80, 80);
         end else begin
            pulse(0, 80, 80);
            pulse(0, 80, 80);
         end
         t1 = t1 + exp_events(2'(sel), 2, 2);
         chk("tally one", 16'(6'(t1)), 16'(channel_one_tally));
         chk("captures", 16'(exp_events(2'(sel), 2, 2)), 16'(caps - c0));
      end
      chk("tally two idle", 16'h0000, 16'(channel_two_tally));
      chk("ext irq", 16'h0001, 16'(event_irq));
      irq_clear = 1'b1;
      tick(1);
      irq_clear = 1'b0;
      tick(2);
      chk("irq cleared", 16'h0000, 16'(event_irq));
      $display("test direct filter done");
      edge_select_two = 2'b10;
      t2 = 6'h00;
      for (int i = 0; i < 2; i++) begin
         n = (i == 0) ? 2 : 3 + int'($urandom % 3);
         channel_two_filter = 6'(n);
         tick(2 * SP);
         pulse(1, (n - 1) * SP - 20, (n + 1) * SP);
         chk("short pulse dropped", 16'(t2), 16'(channel_two_tally));
         pulse(1, n * SP + 20, (n + 1) * SP + 100);
         t2 = t2 + 6'(exp_events(2'b10, 1, 1));
         chk("long pulse counted", 16'(t2), 16'(channel_two_tally));
      end
      $display("test sampled filter done");
      buffer_clear = 1'b1;
      tick(1);
      buffer_clear = 1'b0;
      rtc_subsec = 10'($urandom);
      rtc_bcd_time = {16'h0000, 32'($urandom)};
      {reset_out_status, vdet2_status, osc_stop_status} = 3'($urandom);
      cmd_trigger_enable = 1'b1;
      cmd_trigger_write = 1'b1;
      tick(1);
      cmd_trigger_write = 1'b0;
      tick(3);
      chk("fill one", 16'(FILL_ONE), 16'(record_fill));
      rd_byte(5'h09);
      chk("source cmd", 16'h0020, 16'(rd));
      rd_byte(5'h01);
      chk("subsec", 16'(rtc_subsec[9:2]), 16'(rd));
      rd_byte(5'h02);
      chk("seconds", 16'(rtc_bcd_time[7:0]), 16'(rd));
      rd_byte(5'h08);
      chk("status", 16'({4'h0, reset_out_status, vdet2_status, 1'b0, osc_stop_status}), 16'(rd));
      int_irq_enable = 1'b1;
      reset_out_event = 1'b1;
      tick(1);
      reset_out_event = 1'b0;
      tick(3);
      rd_byte(5'h19);
      chk("record two source", {8'(FILL_FULL), 8'h04}, {8'(record_fill), rd});
      chk("int irq", 16'h0001, 16'(event_irq));
      c0 = caps;
      overwrite_enable = 1'b0;
      vdet2_event = 1'b1;
      tick(1);
      vdet2_event = 1'b0;
      tick(3);
      rd_byte(5'h19);
      chk("inhibit kept", 16'h0004, {8'(caps - c0), rd});
      overwrite_enable = 1'b1;
      osc_resume_event = 1'b1;
      tick(1);
      osc_resume_event = 1'b0;
      tick(3);
      rd_byte(5'h19);
      chk("overwrite", 16'h0010, 16'(rd));
      bin_select = 1'b1;
      rtc_bin_count = {16'h0000, 32'($urandom)};
      cmd_trigger_write = 1'b1;
      tick(1);
      cmd_trigger_write = 1'b0;
      tick(3);
      rd_byte(5'h12);
      chk("binary count", 16'(rtc_bin_count[7:0]), 16'(rd));
      chk("tallies kept", {2'b00, t1[5:0], 2'b00, t2}, {2'b00, channel_one_tally, 2'b00, channel_two_tally});
      sram_mode = 1'b1;
      c0 = caps;
      cmd_trigger_write = 1'b1;
      tick(1);
      cmd_trigger_write = 1'b0;
      sw_addr = 5'h1f;
      sw_wdata = 8'($urandom);
      sw_write = 1'b1;
      tick(1);
      sw_write = 1'b0;
      rd_byte(5'h1f);
      chk("memory mode write", 16'(sw_wdata), 16'(rd));
      chk("no capture in memory mode", 16'h0000, 16'(caps - c0));
      $display("test buffer done");
      finish_test();
   end
endmodule
`default_nettype wire
